// ---- rtl/arc_pkg.sv ----
// Constants for the converter result and calibration pointer register bank
// What this block does
// RULE_01: Bypass clear applies stored channel offset coefficient
// RULE_02: Bypass set corrects with zero offset
// RULE_03: Bypass is one global bit for all
// RULE_04: Result register read only, resets to zero
// RULE_05: Four bit pointer, input channel numbering
// RULE_06: Coefficient windows steered by pointer value
// RULE_07: Changing control two bits aborts conversion
// RULE_08: Offset coefficient is 24 bit per channel
// RULE_09: Offset write dropped during matching conversion
// RULE_10: Reserved bits read zero; pointer resets zero
package arc_pkg;
    localparam int unsigned ARC_AW = 8;
    localparam int unsigned ARC_DW = 24;
    localparam int unsigned ARC_NCH = 16;
    localparam logic [7:0] ARC_OFS_CTRL2 = 8'h23;
    localparam logic [7:0] ARC_OFS_RESULT = 8'h24;
    localparam logic [7:0] ARC_OFS_POINTER = 8'h25;
    localparam logic [7:0] ARC_OFS_OFFSET_WIN = 8'h26;
    localparam logic [7:0] ARC_OFS_GAIN_WIN = 8'h27;
    localparam int unsigned ARC_BIT_EXTCLK = 23;
    localparam int unsigned ARC_BIT_SYNC_MODE = 21;
    localparam int unsigned ARC_BIT_GAIN_BYPASS = 19;
    localparam int unsigned ARC_BIT_OFFSET_BYPASS = 18;
    localparam logic [23:0] ARC_CTRL2_MASK = 24'hac0000;
    localparam logic [23:0] ARC_CTRL2_RESET = 24'h000000;
    localparam logic [23:0] ARC_RESULT_RESET = 24'h000000;
    localparam logic [3:0] ARC_POINTER_RESET = 4'h0;
    localparam logic [23:0] ARC_OFFSET_RESET = 24'h000000;
    localparam logic [23:0] ARC_GAIN_RESET = 24'hc00000;
    localparam logic [23:0] ARC_ZERO_OFFSET = 24'h000000;
endpackage

// ---- rtl/arc_regs.sv ----
// Converter result, control two and indirect calibration coefficient registers
`timescale 1ns/1ps
module arc_regs (
    input wire logic clk,
    input wire logic srst,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [arc_pkg::ARC_AW-1:0] reg_addr,
    input wire logic [arc_pkg::ARC_DW-1:0] reg_wdata,
    output logic [arc_pkg::ARC_DW-1:0] reg_rdata,
    input wire logic result_valid,
    input wire logic [arc_pkg::ARC_DW-1:0] result_data,
    input wire logic conv_busy,
    input wire logic [3:0] active_channel,
    output logic conv_abort,
    output logic [arc_pkg::ARC_DW-1:0] offset_applied,
    output logic [arc_pkg::ARC_DW-1:0] gain_applied,
    output logic gain_bypass,
    output logic offset_bypass,
    output logic ext_clock_sel,
    output logic sync_mode
);
    import arc_pkg::*;

    logic [23:0] ctrl2_q;
    logic [23:0] result_q;
    logic [3:0] pointer_q;
    logic [23:0] offset_mem_q [ARC_NCH];
    logic [23:0] gain_mem_q [ARC_NCH];
    logic [23:0] rdata_q;
    logic abort_q;
    logic [23:0] offset_app_q;
    logic [23:0] gain_app_q;
    logic [23:0] ctrl2_d;
    logic offset_block;

    function automatic logic arc_hit(input logic [7:0] a, input logic [7:0] ofs);
        arc_hit = (a == ofs);
    endfunction

    assign ctrl2_d = reg_wdata & ARC_CTRL2_MASK;
    assign offset_block = conv_busy && (pointer_q == active_channel);

    // Control two register and abort on change
    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl2_q <= ARC_CTRL2_RESET;
            abort_q <= 1'b0;
        end else begin
            abort_q <= 1'b0;
            if (reg_wr && arc_hit(reg_addr, ARC_OFS_CTRL2)) begin
                ctrl2_q <= ctrl2_d; // [RULE_03]
                abort_q <= (ctrl2_d != ctrl2_q) && conv_busy; // [RULE_07]
            end
        end
    end

    // Checks on control two and the abort pulse
    a_abort_quiet: assert property (@(posedge clk) disable iff (srst) // [RULE_07]
        !(reg_wr && reg_addr == ARC_OFS_CTRL2) |=> !conv_abort)
        else $error("abort without control write");
    a_abort_same: assert property (@(posedge clk) disable iff (srst) // [RULE_07]
        reg_wr && reg_addr == ARC_OFS_CTRL2 && ctrl2_d == ctrl2_q |=> !conv_abort)
        else $error("abort on unchanged write");
    a_abort_idle: assert property (@(posedge clk) disable iff (srst) // [RULE_07]
        !conv_busy |=> !conv_abort)
        else $error("abort while idle");
    a_ctrl2_write: assert property (@(posedge clk) disable iff (srst) // [RULE_03]
        reg_wr && reg_addr == ARC_OFS_CTRL2 |=> ctrl2_q == $past(ctrl2_d))
        else $error("control two not written");

    // Result register, loaded only by the datapath
    always_ff @(posedge clk) begin
        if (srst) begin
            result_q <= ARC_RESULT_RESET; // [RULE_04]
        end else if (result_valid) begin
            result_q <= result_data; // [RULE_04]
        end
    end

    // Checks on the result register
    a_result_load: assert property (@(posedge clk) disable iff (srst) // [RULE_04]
        result_valid |=> result_q == $past(result_data))
        else $error("result not loaded");
    a_result_read: assert property (@(posedge clk) disable iff (srst) // [RULE_04]
        reg_rd && reg_addr == ARC_OFS_RESULT |=> rdata_q == $past(result_q))
        else $error("result misread");

    // Coefficient channel pointer
    always_ff @(posedge clk) begin
        if (srst) begin
            pointer_q <= ARC_POINTER_RESET; // [RULE_10]
        end else if (reg_wr && arc_hit(reg_addr, ARC_OFS_POINTER)) begin
            pointer_q <= reg_wdata[3:0]; // [RULE_05]
        end
    end

    // Checks on the pointer
    a_pointer_hold: assert property (@(posedge clk) disable iff (srst) // [RULE_05]
        !(reg_wr && reg_addr == ARC_OFS_POINTER) |=> $stable(pointer_q))
        else $error("pointer changed without write");

    // Per-channel coefficient storage
    generate
        for (genvar ch = 0; ch < ARC_NCH; ch++) begin : g_coef
            always_ff @(posedge clk) begin
                if (srst) begin
                    offset_mem_q[ch] <= ARC_OFFSET_RESET;
                    gain_mem_q[ch] <= ARC_GAIN_RESET;
                end else if (reg_wr && pointer_q == 4'(ch)) begin
                    if (arc_hit(reg_addr, ARC_OFS_OFFSET_WIN) && !offset_block) begin
                        offset_mem_q[ch] <= reg_wdata; // [RULE_06] [RULE_08] [RULE_09]
                    end
                    if (arc_hit(reg_addr, ARC_OFS_GAIN_WIN)) begin
                        gain_mem_q[ch] <= reg_wdata; // [RULE_06]
                    end
                end
            end
        end
    endgenerate

    // Checks on the coefficient windows
    a_gain_write: assert property (@(posedge clk) disable iff (srst) // [RULE_06]
        reg_wr && reg_addr == ARC_OFS_GAIN_WIN |=> gain_mem_q[$past(pointer_q)] == $past(reg_wdata))
        else $error("gain write lost");
    a_offset_read: assert property (@(posedge clk) disable iff (srst) // [RULE_06]
        reg_rd && reg_addr == ARC_OFS_OFFSET_WIN |=> rdata_q == $past(offset_mem_q[pointer_q]))
        else $error("offset window misread");

    // Read data, one cycle after the read strobe
    always_ff @(posedge clk) begin
        if (srst) begin
            rdata_q <= 24'h000000;
        end else if (reg_rd) begin
            if (arc_hit(reg_addr, ARC_OFS_CTRL2)) begin
                rdata_q <= ctrl2_q;
            end else if (arc_hit(reg_addr, ARC_OFS_RESULT)) begin
                rdata_q <= result_q;
            end else if (arc_hit(reg_addr, ARC_OFS_POINTER)) begin
                rdata_q <= {20'h00000, pointer_q}; // [RULE_10]
            end else if (arc_hit(reg_addr, ARC_OFS_OFFSET_WIN)) begin
                rdata_q <= offset_mem_q[pointer_q]; // [RULE_06]
            end else if (arc_hit(reg_addr, ARC_OFS_GAIN_WIN)) begin
                rdata_q <= gain_mem_q[pointer_q]; // [RULE_06]
            end else begin
                rdata_q <= 24'h000000;
            end
        end
    end

    // Checks on read data
    a_rdata_hold: assert property (@(posedge clk) disable iff (srst) // [RULE_06]
        !reg_rd |=> $stable(rdata_q))
        else $error("read data changed without read");
    a_ctrl2_rsv: assert property (@(posedge clk) disable iff (srst) // [RULE_10]
        reg_rd && reg_addr == ARC_OFS_CTRL2 |=> (rdata_q & ~ARC_CTRL2_MASK) == 24'h000000)
        else $error("control two reserved bits set");
    a_unmapped_zero: assert property (@(posedge clk) disable iff (srst) // [RULE_10]
        reg_rd && reg_addr != ARC_OFS_CTRL2 && reg_addr != ARC_OFS_RESULT && reg_addr != ARC_OFS_POINTER
        && reg_addr != ARC_OFS_OFFSET_WIN && reg_addr != ARC_OFS_GAIN_WIN |=> rdata_q == 24'h000000)
        else $error("unmapped read not zero");

    // Coefficients handed to the correction datapath
    always_ff @(posedge clk) begin
        if (srst) begin
            offset_app_q <= ARC_ZERO_OFFSET;
            gain_app_q <= ARC_GAIN_RESET;
        end else begin
            if (ctrl2_q[ARC_BIT_OFFSET_BYPASS]) begin
                offset_app_q <= ARC_ZERO_OFFSET; // [RULE_02] [RULE_03]
            end else begin
                offset_app_q <= offset_mem_q[active_channel]; // [RULE_01]
            end
            gain_app_q <= gain_mem_q[active_channel];
        end
    end

    // Checks on the coefficients handed on
    a_gain_applied: assert property (@(posedge clk) disable iff (srst) // [RULE_06]
        1'b1 |=> gain_app_q == $past(gain_mem_q[active_channel]))
        else $error("gain not handed on");

    assign reg_rdata = rdata_q;
    assign conv_abort = abort_q;
    assign offset_applied = offset_app_q;
    assign gain_applied = gain_app_q;
    assign gain_bypass = ctrl2_q[ARC_BIT_GAIN_BYPASS];
    assign offset_bypass = ctrl2_q[ARC_BIT_OFFSET_BYPASS];
    assign ext_clock_sel = ctrl2_q[ARC_BIT_EXTCLK];
    assign sync_mode = ctrl2_q[ARC_BIT_SYNC_MODE];

    // Checks on storage, pointer, bypass, result and abort
    a_offset_used: assert property (@(posedge clk) disable iff (srst) // [RULE_01]
        !ctrl2_q[ARC_BIT_OFFSET_BYPASS] |=> offset_app_q == $past(offset_mem_q[active_channel]))
        else $error("offset not applied");
    a_bypass_zero: assert property (@(posedge clk) disable iff (srst) // [RULE_02]
        ctrl2_q[ARC_BIT_OFFSET_BYPASS] |=> offset_app_q == ARC_ZERO_OFFSET)
        else $error("bypass offset not zero");
    a_bypass_keeps: assert property (@(posedge clk) disable iff (srst) // [RULE_03]
        ctrl2_q[ARC_BIT_OFFSET_BYPASS] && !reg_wr |=> $stable(offset_mem_q[pointer_q]))
        else $error("bypass changed storage");
    a_result_ro: assert property (@(posedge clk) disable iff (srst) // [RULE_04]
        !result_valid |=> $stable(result_q))
        else $error("result changed without result");
    a_pointer_wr: assert property (@(posedge clk) disable iff (srst) // [RULE_05]
        reg_wr && reg_addr == ARC_OFS_POINTER |=> pointer_q == $past(reg_wdata[3:0]))
        else $error("pointer not written");
    a_window_read: assert property (@(posedge clk) disable iff (srst) // [RULE_06]
        reg_rd && reg_addr == ARC_OFS_GAIN_WIN |=> rdata_q == $past(gain_mem_q[pointer_q]))
        else $error("gain window misread");
    a_abort_change: assert property (@(posedge clk) disable iff (srst) // [RULE_07]
        reg_wr && reg_addr == ARC_OFS_CTRL2 && conv_busy && ctrl2_d != ctrl2_q |=> conv_abort)
        else $error("abort missing");
    a_offset_write: assert property (@(posedge clk) disable iff (srst) // [RULE_08]
        reg_wr && reg_addr == ARC_OFS_OFFSET_WIN && !offset_block
        |=> offset_mem_q[$past(pointer_q)] == $past(reg_wdata))
        else $error("offset write lost");
    a_offset_block: assert property (@(posedge clk) disable iff (srst) // [RULE_09]
        reg_wr && reg_addr == ARC_OFS_OFFSET_WIN && offset_block |=> $stable(offset_mem_q[pointer_q]))
        else $error("blocked offset write landed");
    a_pointer_rsv: assert property (@(posedge clk) disable iff (srst) // [RULE_10]
        reg_rd && reg_addr == ARC_OFS_POINTER |=> rdata_q[23:4] == 20'h00000)
        else $error("pointer reserved bits set");
endmodule

// ---- verif/adc_result_and_cal_pointer_bench.sv ----
// Self-checking bench for the result and calibration pointer registers
`timescale 1ns/1ps
module adc_result_and_cal_pointer_bench;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic reg_wr, reg_rd, result_valid, conv_busy, conv_abort, offset_bypass;
    logic gain_bypass, ext_clock_sel, sync_mode;
    logic [23:0] gain_applied;
    logic [7:0] reg_addr;
    logic [23:0] reg_wdata, reg_rdata, result_data, offset_applied, v, off_m[16];
    logic [3:0] active_channel;
    int error_cnt = 0;
    int samples_checked = 0;
    int seed = 32'h21f1;
    always #2 clk = ~clk;
    arc_regs arc_regs_i (.clk(clk), .srst(srst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .result_valid(result_valid), .result_data(result_data),
        .conv_busy(conv_busy), .active_channel(active_channel), .conv_abort(conv_abort),
        .offset_applied(offset_applied), .gain_applied(gain_applied), .gain_bypass(gain_bypass),
        .offset_bypass(offset_bypass), .ext_clock_sel(ext_clock_sel), .sync_mode(sync_mode));
    arc_host arc_host_i (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rc(input logic [7:0] a, input logic [23:0] exp);
        logic [23:0] d;
        arc_host_i.rd(a, d);
        chk(d, exp);
    endtask
    task automatic report_and_stop;
        $display("checks=%0d errors=%0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        #40000;
        error_cnt++;
        report_and_stop();
    end
    initial begin
        result_valid = 1'b0;
        result_data = 24'h000000;
        conv_busy = 1'b0;
        active_channel = 4'h0;
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        rc(8'h24, 24'h000000);
        rc(8'h25, 24'h000000);
        v = 24'($random(seed));
        @(posedge clk);
        result_valid <= 1'b1;
        result_data <= v;
        @(posedge clk);
        result_valid <= 1'b0;
        arc_host_i.wr(8'h24, ~v);
        rc(8'h24, v);
        arc_host_i.wr(8'h25, 24'hfffff5);
        rc(8'h25, 24'h000005);
        for (int i = 0; i < 16; i++) begin
            off_m[i] = 24'($random(seed));
            arc_host_i.wr(8'h25, 24'(i));
            arc_host_i.wr(8'h26, off_m[i]);
        end
        for (int i = 0; i < 16; i++) begin
            arc_host_i.wr(8'h25, 24'(i));
            rc(8'h26, off_m[i]);
            @(posedge clk) active_channel <= 4'(i);
            repeat (2) @(posedge clk);
            #1 chk(offset_applied, off_m[i]);
        end
        arc_host_i.wr(8'h23, 24'h040000);
        #1 chk({23'h0, offset_bypass}, 24'h000001);
        for (int i = 0; i < 16; i++) begin
            @(posedge clk) active_channel <= 4'(i);
            repeat (2) @(posedge clk);
            #1 chk(offset_applied, 24'h000000);
        end
        rc(8'h26, off_m[15]);
        arc_host_i.wr(8'h23, 24'hffffff);
        #1 chk({23'h0, conv_abort}, 24'h000000);
        rc(8'h23, 24'hac0000);
        chk({20'h0, ext_clock_sel, sync_mode, gain_bypass, offset_bypass}, 24'h00000f);
        rc(8'h30, 24'h000000);
        arc_host_i.wr(8'h23, 24'h040000);
        v = 24'($random(seed));
        arc_host_i.wr(8'h27, v);
        rc(8'h27, v);
        chk(gain_applied, v);
        arc_host_i.wr(8'h25, 24'h000000);
        rc(8'h27, 24'hc00000);
        rc(8'h26, off_m[0]);
        arc_host_i.wr(8'h25, 24'h00000f);
        @(posedge clk) conv_busy <= 1'b1;
        arc_host_i.wr(8'h23, 24'h040000);
        #1 chk({23'h0, conv_abort}, 24'h000000);
        arc_host_i.wr(8'h23, 24'h000000);
        #1 chk({23'h0, conv_abort}, 24'h000001);
        arc_host_i.wr(8'h26, ~off_m[15]);
        rc(8'h26, off_m[15]);
        off_m[3] = 24'($random(seed));
        arc_host_i.wr(8'h25, 24'h000003);
        arc_host_i.wr(8'h26, off_m[3]);
        rc(8'h26, off_m[3]);
        report_and_stop();
    end
endmodule

// ---- verif/arc_host.sv ----
// Host model issuing single-cycle register strobes
`timescale 1ns/1ps
module arc_host (
    input wire logic clk,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_addr,
    output logic [23:0] reg_wdata,
    input wire logic [23:0] reg_rdata
);
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 24'h000000;
    end
    task automatic wr(input logic [7:0] a, input logic [23:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [23:0] d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
endmodule
